// File: adsc_map.svh
// Operation
// - fifth config bit one unipolar, zero bipolar
// - unipolar result is straight binary
// - bipolar result is two's complement
// - sixth config bit one MSB first, zero LSB first
// - config word always received in fixed order
// - length code 00=8, 10=12, 11=16, 01=shutdown
// - length code applies to the same transfer
// - code 01 enters shutdown instead of converting
// - shutdown transfer shifts previous result as 10 bits
// - wake on select fall or clock edge
// - select pulses under one conversion clock ignored
// - select recognised after two falling conversion edges
// - recognised select turns serial output on
// - shift clocks ignored while select high
// - with select low, first bit shown after conversion
// - first eight rising edges capture config word
// - drive on falling edge, sample on rising edge
// - conversion starts at transfer end, result next
// - 16-bit words pad four trailing zeros
`ifndef ADSC_MAP_SVH
`define ADSC_MAP_SVH

`define ADSC_CFG_BITS 5'h08
`define ADSC_CFG_INCFG 7
`define ADSC_CFG_CHAN_HI 6
`define ADSC_CFG_CHAN_LO 4
`define ADSC_CFG_POL 3
`define ADSC_CFG_ORDER 2
`define ADSC_CFG_LEN_HI 1
`define ADSC_CFG_LEN_LO 0
`define ADSC_CFG_RESET 8'hFE

`define ADSC_RES_BITS 5'h0C
`define ADSC_RES_SIGN 12'h800
`define ADSC_RES_RESET 12'h000

`define ADSC_CODE_8 2'h0
`define ADSC_CODE_SHDN 2'h1
`define ADSC_CODE_12 2'h2
`define ADSC_CODE_16 2'h3
`define ADSC_LEN_8 5'h08
`define ADSC_LEN_SHDN 5'h0A
`define ADSC_LEN_12 5'h0C
`define ADSC_LEN_16 5'h10
`define ADSC_LEN_MAX 5'h10

`define ADSC_DEGLITCH_EDGES 2'h2

`endif

// File: adsc_pkg.sv
`default_nettype none
package adsc_pkg;
`include "adsc_map.svh"

  typedef enum logic [1:0] {
    ADSC_IDLE = 2'h0,
    ADSC_CONV = 2'h1,
    ADSC_SHDN = 2'h2
  } adsc_state_e;

  typedef struct packed {
    logic input_config_select;
    logic [2:0] channel_address;
    logic polarity_select;
  } adsc_conv_req_s;

  typedef struct packed {
    logic output_order_select;
    logic [11:0] code;
  } adsc_result_s;

  function automatic logic [4:0] adsc_word_len(input logic [1:0] code);
    logic [4:0] len;
    begin
      unique case (code)
        `ADSC_CODE_8: len = `ADSC_LEN_8;
        `ADSC_CODE_SHDN: len = `ADSC_LEN_SHDN;
        `ADSC_CODE_12: len = `ADSC_LEN_12;
        `ADSC_CODE_16: len = `ADSC_LEN_16;
      endcase
      return len;
    end
  endfunction

  function automatic logic adsc_out_bit(input adsc_result_s r, input logic [4:0] j);
    logic [4:0] k;
    begin
      k = r.output_order_select ? 5'(5'h0B - j) : j;
      return (j < `ADSC_RES_BITS) ? r.code[k[3:0]] : 1'b0;
    end
  endfunction

endpackage
`default_nettype wire

// File: adsc_port.sv
`timescale 1ns/10ps
`default_nettype none
module adsc_port
  import adsc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  input wire logic i_aclk,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe_n,
  output logic o_conv_start,
  output adsc_conv_req_s o_conv_req,
  input wire logic i_conv_done,
  input wire logic [11:0] i_conv_code,
  output logic o_shutdown
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic cs_s1;
  logic cs_s2;
  logic ak_s1;
  logic ak_s2;
  logic ak_s3;
  logic done_s1;
  logic done_s2;
  logic done_s3;
  logic edge_s1;
  logic edge_s2;
  logic edge_s3;
  logic cs_rec_n;
  logic next_cs_rec_n;
  logic [1:0] dg_cnt;
  logic [1:0] next_dg_cnt;
  logic cs_act;
  logic cs_act_d;
  logic aclk_fall;
  logic done_ev;
  logic edge_ev;

  adsc_state_e state;
  adsc_state_e next_state;
  logic next_conv_start;
  adsc_conv_req_s next_conv_req;
  logic req_order;
  logic next_req_order;
  adsc_result_s res;
  adsc_result_s next_res;
  logic first_bit;
  logic next_first_bit;
  logic next_shutdown;

  logic link_rstn;
  logic link_clr;
  logic next_link_clr;
  logic [4:0] rise_cnt;
  logic [4:0] next_rise_cnt;
  logic [7:0] cfg_shift;
  logic [7:0] next_cfg_shift;
  logic [7:0] cfg_word;
  logic [7:0] next_cfg_word;
  logic done_tgl;
  logic next_done_tgl;
  logic edge_tgl;
  logic next_edge_tgl;
  logic [4:0] len_now;
  logic [4:0] fall_cnt;
  logic [4:0] next_fall_cnt;
  logic dout_q;
  logic next_dout_q;
  logic [4:0] fall_lim;

  ////////////////////////////////////////////////////////////////////////////
  // pin and toggle synchronisers, conversion clock edge

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      ak_s1 <= 1'b0;
      ak_s2 <= 1'b0;
      ak_s3 <= 1'b0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      edge_s1 <= 1'b0;
      edge_s2 <= 1'b0;
      edge_s3 <= 1'b0;
      cs_act_d <= 1'b0;
    end else if (i_clk_en) begin
      cs_s1 <= i_cs_n;
      cs_s2 <= cs_s1;
      ak_s1 <= i_aclk;
      ak_s2 <= ak_s1;
      ak_s3 <= ak_s2;
      done_s1 <= done_tgl;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      edge_s1 <= edge_tgl;
      edge_s2 <= edge_s1;
      edge_s3 <= edge_s2;
      cs_act_d <= cs_act;
    end
  end

  assign aclk_fall = ak_s3 & ~ak_s2;
  assign done_ev = done_s2 ^ done_s3;
  assign edge_ev = edge_s2 ^ edge_s3;
  assign cs_act = ~cs_rec_n;

  ////////////////////////////////////////////////////////////////////////////
  // select deglitcher

  always_comb begin
    next_cs_rec_n = cs_rec_n;
    next_dg_cnt = dg_cnt;
    if (cs_s2 == cs_rec_n) begin
      next_dg_cnt = 2'h0;
    end else if (aclk_fall) begin
      if (2'(dg_cnt + 2'h1) == `ADSC_DEGLITCH_EDGES) begin
        next_cs_rec_n = cs_s2;
        next_dg_cnt = 2'h0;
      end else begin
        next_dg_cnt = 2'(dg_cnt + 2'h1);
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_rec_n <= 1'b1;
      dg_cnt <= 2'h0;
      o_dout_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      cs_rec_n <= next_cs_rec_n;
      dg_cnt <= next_dg_cnt;
      o_dout_oe_n <= next_cs_rec_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion control and result word

  always_comb begin
    next_state = state;
    next_conv_start = 1'b0;
    next_conv_req = o_conv_req;
    next_req_order = req_order;
    next_res = res;
    next_link_clr = 1'b0;
    unique case (state)
      ADSC_IDLE: begin
        if (done_ev) begin
          if (cfg_word[`ADSC_CFG_LEN_HI:`ADSC_CFG_LEN_LO] == `ADSC_CODE_SHDN) begin
            next_state = ADSC_SHDN;
          end else begin
            next_state = ADSC_CONV;
            next_conv_start = 1'b1;
            next_conv_req.input_config_select = cfg_word[`ADSC_CFG_INCFG];
            next_conv_req.channel_address = cfg_word[`ADSC_CFG_CHAN_HI:`ADSC_CFG_CHAN_LO];
            next_conv_req.polarity_select = cfg_word[`ADSC_CFG_POL];
            next_req_order = cfg_word[`ADSC_CFG_ORDER];
          end
        end
      end
      ADSC_CONV: begin
        if (i_conv_done) begin
          next_state = ADSC_IDLE;
          next_link_clr = 1'b1;
          next_res.output_order_select = req_order;
          if (o_conv_req.polarity_select) begin
            next_res.code = i_conv_code;
          end else begin
            next_res.code = i_conv_code ^ `ADSC_RES_SIGN;
          end
        end
      end
      ADSC_SHDN: begin
        if (cs_act && (!cs_act_d || edge_ev)) begin
          next_state = ADSC_IDLE;
        end
      end
      default: begin
        next_state = ADSC_IDLE;
      end
    endcase
    next_shutdown = (next_state == ADSC_SHDN);
    next_first_bit = adsc_out_bit(next_res, 5'h00);
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ADSC_IDLE;
      o_conv_start <= 1'b0;
      o_conv_req <= '0;
      req_order <= 1'b1;
      link_clr <= 1'b0;
      res <= {1'b1, `ADSC_RES_RESET};
      first_bit <= 1'b0;
      o_shutdown <= 1'b0;
    end else if (i_clk_en) begin
      state <= next_state;
      o_conv_start <= next_conv_start;
      o_conv_req <= next_conv_req;
      req_order <= next_req_order;
      link_clr <= next_link_clr;
      res <= next_res;
      first_bit <= next_first_bit;
      o_shutdown <= next_shutdown;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift clock domain: capture on rising edges

  // link logic held clear while select is not recognised, and re-armed
  // after a conversion that ran with select held low
  assign link_rstn = i_rstn & cs_act & ~link_clr;

  assign len_now = (rise_cnt == 5'h07) ?
    adsc_word_len({cfg_shift[0], i_din}) :
    adsc_word_len(cfg_word[`ADSC_CFG_LEN_HI:`ADSC_CFG_LEN_LO]);

  always_comb begin
    next_rise_cnt = rise_cnt;
    next_cfg_shift = cfg_shift;
    next_cfg_word = cfg_word;
    next_done_tgl = done_tgl;
    next_edge_tgl = ~edge_tgl;
    if (rise_cnt < `ADSC_CFG_BITS) begin
      next_cfg_shift = {cfg_shift[6:0], i_din};
    end
    if (rise_cnt == 5'h07) begin
      next_cfg_word = {cfg_shift[6:0], i_din};
    end
    if ((rise_cnt < `ADSC_CFG_BITS) || (rise_cnt < len_now)) begin
      next_rise_cnt = 5'(rise_cnt + 5'h01);
      if (5'(rise_cnt + 5'h01) == len_now) begin
        next_done_tgl = ~done_tgl;
      end
    end
  end

  always_ff @(posedge i_sclk or negedge link_rstn) begin
    if (!link_rstn) begin
      rise_cnt <= 5'h00;
      cfg_shift <= 8'h00;
    end else begin
      rise_cnt <= next_rise_cnt;
      cfg_shift <= next_cfg_shift;
    end
  end

  always_ff @(posedge i_sclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_word <= `ADSC_CFG_RESET;
      done_tgl <= 1'b0;
      edge_tgl <= 1'b0;
    end else begin
      cfg_word <= next_cfg_word;
      done_tgl <= next_done_tgl;
      edge_tgl <= next_edge_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift clock domain: drive on falling edges

  assign fall_lim = (rise_cnt >= `ADSC_CFG_BITS) ?
    adsc_word_len(cfg_word[`ADSC_CFG_LEN_HI:`ADSC_CFG_LEN_LO]) : `ADSC_LEN_MAX;

  always_comb begin
    next_fall_cnt = fall_cnt;
    next_dout_q = 1'b0;
    if (fall_cnt < fall_lim) begin
      next_fall_cnt = 5'(fall_cnt + 5'h01);
      if (next_fall_cnt < fall_lim) begin
        next_dout_q = adsc_out_bit(res, next_fall_cnt);
      end
    end
  end

  always_ff @(negedge i_sclk or negedge link_rstn) begin
    if (!link_rstn) begin
      fall_cnt <= 5'h00;
      dout_q <= 1'b0;
    end else begin
      fall_cnt <= next_fall_cnt;
      dout_q <= next_dout_q;
    end
  end

  // first bit is shown before any falling shift edge exists
  assign o_dout = (fall_cnt == 5'h00) ? first_bit : dout_q;

endmodule
`default_nettype wire

// File: adsc_port_chk.sv
`timescale 1ns/10ps
`default_nettype none
module adsc_port_chk
  import adsc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_cs_n,
  input wire logic o_dout_oe_n,
  input wire logic o_conv_start,
  input wire adsc_conv_req_s o_conv_req,
  input wire logic o_shutdown
);
  // cycles the select pin has held its level, saturating
  logic [4:0] hi, lo, next_hi, next_lo;
  always_comb begin
    next_hi = i_cs_n ? hi + 5'(hi != 5'h14) : 5'h00;
    next_lo = i_cs_n ? 5'h00 : lo + 5'(lo != 5'h14);
  end
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      hi <= 5'h00;
      lo <= 5'h00;
    end else begin
      hi <= next_hi;
      lo <= next_lo;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  sequence sel_fall_s; o_shutdown && $fell(o_dout_oe_n); endsequence
  sequence wake_s; ##[0:6] !o_shutdown; endsequence
  sel_early_a: assert property ($fell(o_dout_oe_n) |-> !$past(i_cs_n, 5))
    else $error("select taken too early");
  desel_early_a: assert property ($rose(o_dout_oe_n) |-> $past(i_cs_n, 5))
    else $error("release taken too early");
  sel_on_a: assert property (lo == 5'h14 |-> !o_dout_oe_n)
    else $error("output not driven");
  sel_off_a: assert property (hi == 5'h14 |-> o_dout_oe_n)
    else $error("output not released");
  start_frame_a: assert property (o_conv_start |-> !$past(o_dout_oe_n, 2))
    else $error("start outside transfer");
  req_hold_a: assert property (!o_conv_start |-> $stable(o_conv_req))
    else $error("request moved");
  shdn_excl_a: assert property (o_shutdown |-> !o_conv_start)
    else $error("start in shutdown");
  wake_sel_a: assert property (sel_fall_s |-> wake_s)
    else $error("no wake on select");
endmodule
`default_nettype wire

// File: adsc_host.sv
`timescale 1ns/10ps
`default_nettype none
module adsc_host (
  input wire logic i_clock,
  input wire logic i_dout,
  input wire logic i_dout_oe_n,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din
);
  int timeouts = 0;
  initial begin
    o_cs_n = 1'h1;
    o_sclk = 1'h0;
    o_din = 1'h0;
  end
  task automatic wait_oe(input logic lvl);
    for (int k = 0; k < 100 && i_dout_oe_n !== lvl; k++) @(negedge i_clock);
    if (i_dout_oe_n !== lvl) timeouts++;
  endtask
  task automatic xfer(input logic [7:0] cfg, input int n, input logic keep,
    output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge i_clock);
    o_cs_n = 1'h0;
    wait_oe(1'h0);
    #3;
    for (int j = 0; j < n; j++) begin
      o_din = (j < 8) ? cfg[7 - j] : ~o_din;
      #32 rx = {rx[14:0], i_dout};
      o_sclk = 1'h1;
      #32 o_sclk = 1'h0;
    end
    o_din = ~o_din;
    if (!keep) begin
      @(negedge i_clock);
      o_cs_n = 1'h1;
      wait_oe(1'h1);
    end
  endtask
  // one shift clock pulse with select still low, then select released
  task automatic tick;
    #32 o_sclk = 1'h1;
    #32 o_sclk = 1'h0;
    repeat (10) @(negedge i_clock);
    o_cs_n = 1'h1;
    wait_oe(1'h1);
  endtask
  // short select pulse, then clocks while deselected
  task automatic glitch(input int width);
    @(negedge i_clock);
    o_cs_n = 1'h0;
    #width o_cs_n = 1'h1;
    repeat (8) begin
      #32 o_sclk = 1'h1;
      #32 o_sclk = 1'h0;
    end
  endtask
endmodule
`default_nettype wire

// File: adsc_port_test.sv
`timescale 1ns/10ps
`default_nettype none
module adsc_port_test;
  import adsc_pkg::*;
  logic i_clock, i_rstn, i_aclk, done, cs_n, sclk, din, dout, oe_n, start, shdn;
  logic [11:0] code;
  logic [11:0] res = 12'h000;
  logic ord = 1'h1;
  adsc_conv_req_s req, req_seen;
  int miscompares = 0;
  int compares = 0;
  int starts = 0;
  int cnt = 0;
  int oe_lows = 0;
  adsc_port u_adsc_port (.i_clock(i_clock), .i_rstn(i_rstn), .i_clk_en(1'h1),
    .i_aclk(i_aclk), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .o_dout(dout),
    .o_dout_oe_n(oe_n), .o_conv_start(start), .o_conv_req(req), .i_conv_done(done),
    .i_conv_code(code), .o_shutdown(shdn));
  adsc_host u_adsc_host (.i_clock(i_clock), .i_dout(dout), .i_dout_oe_n(oe_n),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
  initial begin
    i_clock = 1'h0;
    forever #10 i_clock = ~i_clock;
  end
  initial begin
    i_aclk = 1'h0;
    #7;
    forever #50 i_aclk = ~i_aclk;
  end
  // converter core stand-in: done 20 cycles after start
  always @(negedge i_clock) begin
    done <= (cnt == 1);
    if (cnt != 0) cnt <= cnt - 1;
    if (oe_n === 1'h0) oe_lows <= oe_lows + 1;
    if (start === 1'h1) begin
      cnt <= 20;
      starts <= starts + 1;
      req_seen <= req;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [15:0] exp_word(logic [11:0] r, logic m, int len, int n);
    logic [15:0] w = 16'h0000;
    for (int j = 0; j < n; j++) w = {w[14:0], (j < len && j < 12) ? r[m ? 11 - j : j] : 1'h0};
    return w;
  endfunction
  task automatic xfer(input string nm, input logic [7:0] cfg, input int n, input logic keep,
    input logic [11:0] c);
    logic [15:0] rx;
    int s = starts;
    int len = cfg[1] ? (cfg[0] ? 16 : 12) : (cfg[0] ? 10 : 8);
    code = c;
    u_adsc_host.xfer(cfg, n, keep, rx);
    check("oe_wait", 16'(u_adsc_host.timeouts), 16'h0000);
    check(nm, rx, exp_word(res, ord, len, n));
    repeat (60) @(negedge i_clock);
    if (len == 10) begin
      check("shutdown", 16'(shdn), 16'h0001);
      check("no_start", 16'(starts), 16'(s));
    end else begin
      check("start", 16'(starts), 16'(s + 1));
      check("req", 16'(req_seen), 16'(cfg[7:3]));
      check("awake", 16'(shdn), 16'h0000);
      res = cfg[3] ? c : c ^ 12'h800;
      ord = cfg[2];
    end
  endtask
  task automatic t_words;
    check("idle_oe", 16'(oe_n), 16'h0001);
    xfer("w12", 8'hAE, 12, 1'h0, 12'hA53);
    xfer("w16", 8'h53, 16, 1'h0, 12'h5C1);
    xfer("w8", 8'hFC, 10, 1'h0, 12'h3FF);
  endtask
  task automatic t_shutdown;
    xfer("shdn", 8'h05, 10, 1'h0, 12'h000);
    xfer("wake", 8'hAE, 12, 1'h0, 12'h001);
    xfer("shdn_low", 8'h05, 10, 1'h1, 12'h000);
    u_adsc_host.tick;
    check("edge_wake", 16'(shdn), 16'h0000);
  endtask
  task automatic t_held;
    xfer("held", 8'h86, 12, 1'h1, 12'h123);
    xfer("held_next", 8'hD2, 12, 1'h0, 12'h456);
  endtask
  task automatic t_filter;
    int s = starts;
    int o = oe_lows;
    u_adsc_host.glitch(40);
    repeat (30) @(negedge i_clock);
    check("glitch_oe", 16'(oe_n), 16'h0001);
    check("glitch_on", 16'(oe_lows), 16'(o));
    check("idle_clk", 16'(starts), 16'(s));
    xfer("after", 8'h5F, 16, 1'h0, 12'h800);
  endtask
  initial begin
    i_rstn = 1'h0;
    code = 12'h000;
    done = 1'h0;
    repeat (3) @(negedge i_clock);
    i_rstn = 1'h1;
    repeat (4) @(negedge i_clock);
    t_words;
    t_shutdown;
    t_held;
    t_filter;
    summarize;
  end
  initial begin
    #200000;
    miscompares++;
    summarize;
  end
endmodule
bind adsc_port adsc_port_chk u_adsc_port_chk (.i_clock(i_clock), .i_rstn(i_rstn),
  .i_cs_n(i_cs_n), .o_dout_oe_n(o_dout_oe_n), .o_conv_start(o_conv_start),
  .o_conv_req(o_conv_req), .o_shutdown(o_shutdown));
`default_nettype wire
